// ### pkg/cmt_pkg.sv
// constants, presets and types shared by the colour matrix transform
package cmt_pkg;

  localparam int PIX_W_DEFAULT = 10;
  localparam int COEF_W = 16;
  localparam int COEF_FRAC = 10;
  localparam int ACC_W = 40;
  localparam int NUM_COEF = 12;
  localparam int NUM_GAIN = 9;
  localparam int PIPE_STAGES = 4;
  localparam int SEL_W = 4;

  localparam logic signed [COEF_W-1:0] COEF_ONE = 16'sh0400;
  localparam logic signed [COEF_W-1:0] COEF_ZERO = 16'sh0000;
  localparam logic [COEF_W-1:0] SAT_RESET = 16'h0400;
  localparam logic [COEF_W-1:0] RATIO_RESET = 16'h0400;

  // transform unit select encodings
  localparam logic UNIT_CORRECTION = 1'b0;
  localparam logic UNIT_LUMA = 1'b1;

  // coefficient select: gains row*3+col, then the three offsets
  localparam logic [SEL_W-1:0] SEL_COEFF_ROW0_COL0 = 4'h0;
  localparam logic [SEL_W-1:0] SEL_BIAS_CHANNEL0 = 4'h9;

  typedef enum logic [2:0] {
    CMT_GENERAL,
    CMT_TUNGSTEN,
    CMT_WARM_FLUOR,
    CMT_COOL_FLUOR,
    CMT_DAYLIGHT,
    CMT_CLOUDY,
    CMT_SHADE,
    CMT_CUSTOM
  } cmt_preset_type;

  typedef logic signed [COEF_W-1:0] cmt_coef_set_type [NUM_COEF];

  // calibration tables per preset: red and blue diagonal gains, white ratios
  localparam logic signed [COEF_W-1:0] PRESET_RED_GAIN [8] = '{
    16'sh0400, 16'sh0300, 16'sh0340, 16'sh03a0, 16'sh0400, 16'sh0440, 16'sh0480, 16'sh0400};
  localparam logic signed [COEF_W-1:0] PRESET_BLUE_GAIN [8] = '{
    16'sh0400, 16'sh0580, 16'sh0520, 16'sh0480, 16'sh0400, 16'sh03c0, 16'sh0380, 16'sh0400};
  localparam logic [COEF_W-1:0] PRESET_RED_RATIO [8] = '{
    16'h0400, 16'h0300, 16'h0340, 16'h03a0, 16'h0400, 16'h0440, 16'h0480, 16'h0400};
  localparam logic [COEF_W-1:0] PRESET_BLUE_RATIO [8] = '{
    16'h0400, 16'h0580, 16'h0520, 16'h0480, 16'h0400, 16'h03c0, 16'h0380, 16'h0400};

  // fixed luma/chroma matrix; chroma offsets are pixel units
  localparam cmt_coef_set_type LUMA_SET = '{
    16'sh0132, 16'sh0259, 16'sh0075,
    -16'sh00ad, -16'sh0153, 16'sh0200,
    16'sh0200, -16'sh01ad, -16'sh0053,
    16'sh0000, 16'sh0200, 16'sh0200};

endpackage

// ### hdl/cmt_color_matrix_transform.sv
// colour correction, saturation and luma/chroma matrix pipeline
`timescale 1ns/1ps

// Summary of operation
// - each output channel is a 3x3 gain matrix times rgb plus offset
// - two separate transforms: correction matrix and luma/chroma matrix
// - unit select picks which transform the enable and coefficient ports address
// - correction enable written 0 bypasses, written 1 applies the matrix
// - illuminant preset picks the active correction matrix from stored tables
// - user coefficient writes accepted and used only with the custom preset
// - preset change loads white ratios; later ratio writes override them
// - luma/chroma conversion is the last stage, after correction
// - luma/chroma active only for yuv formats; its enable is read only
// - coefficient select addresses nine gains then three offsets
// - coefficient readback returns the value in use at the selected position
// - gains held as signed fractional values with ten fraction bits; offsets are signed whole pixel units
// - saturation applied only when enabled; larger setting gives more vivid colour
// - correction, preset and saturation controls take effect, and transform enable and coefficients read back, only while pipe is on
module cmt_color_matrix_transform
  import cmt_pkg::*;
#(
  parameter int PIX_W = PIX_W_DEFAULT
) (
  input wire logic i_clock, // 100 MHz clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_pix_valid, // input pixel valid
  input wire logic i_pix_sof, // input start of frame marker
  input wire logic i_pix_eol, // input end of line marker
  input wire logic [PIX_W-1:0] i_red, // input red
  input wire logic [PIX_W-1:0] i_green, // input green
  input wire logic [PIX_W-1:0] i_blue, // input blue
  output logic o_pix_valid, // output pixel valid
  output logic o_pix_sof, // output start of frame marker
  output logic o_pix_eol, // output end of line marker
  output logic [PIX_W-1:0] o_ch0, // output channel 0 (r or luma)
  output logic [PIX_W-1:0] o_ch1, // output channel 1 (g or cb)
  output logic [PIX_W-1:0] o_ch2, // output channel 2 (b or cr)
  input wire logic i_image_pipe_on, // pipeline enable, gates controls
  input wire logic i_yuv_format, // output pixel format is yuv/ycbcr
  input wire logic i_transform_unit_select, // 0 correction, 1 luma/chroma
  input wire logic i_transform_apply_wr, // write strobe for apply enable
  input wire logic i_transform_apply_on, // apply enable write data
  output logic o_transform_apply_on, // enable of selected unit
  input wire logic [SEL_W-1:0] i_coefficient_select, // gain or offset index
  input wire logic i_coefficient_wr, // coefficient write strobe
  input wire logic [COEF_W-1:0] i_coefficient_value, // coefficient write data
  output logic [COEF_W-1:0] o_coefficient_value, // coefficient readback
  input wire logic [2:0] i_illuminant_preset, // preset, 7 is custom
  input wire logic i_ratio_wr, // white ratio override strobe
  input wire logic [COEF_W-1:0] i_red_white_ratio, // red ratio write data
  input wire logic [COEF_W-1:0] i_blue_white_ratio, // blue ratio write data
  output logic [COEF_W-1:0] o_red_white_ratio, // current red white ratio
  output logic [COEF_W-1:0] o_blue_white_ratio, // current blue white ratio
  input wire logic i_chroma_boost_on, // saturation adjust enable
  input wire logic [COEF_W-1:0] i_saturation // saturation, 0x0400 is unity
);

  // refuse widths whose clamp or products would not fit the accumulator
  if (PIX_W < 2 || PIX_W > 16) begin : g_width_check
    $error("cmt_color_matrix_transform: PIX_W must be 2 to 16");
  end

  localparam logic signed [ACC_W-1:0] PIX_MAX = ACC_W'((64'sd1 <<< PIX_W) - 64'sd1);

  // scale back from fraction bits and saturate into the pixel range
  function automatic logic [PIX_W-1:0] clamp_pix(input logic signed [ACC_W-1:0] acc);
    logic signed [ACC_W-1:0] s;
    s = acc >>> COEF_FRAC;
    if (s < 0) begin
      return '0;
    end else if (s > PIX_MAX) begin
      return PIX_MAX[PIX_W-1:0];
    end
    return s[PIX_W-1:0];
  endfunction

  function automatic logic signed [ACC_W-1:0] pix_ext(input logic [PIX_W-1:0] p);
    return ACC_W'($signed({1'b0, p}));
  endfunction

  // one matrix row dotted with rgb plus that row's offset
  function automatic logic [PIX_W-1:0] row_dot(input cmt_coef_set_type c, input int k,
      input logic [PIX_W-1:0] r, input logic [PIX_W-1:0] g, input logic [PIX_W-1:0] b);
    logic signed [ACC_W-1:0] acc;
    acc = ACC_W'(c[3*k]) * pix_ext(r);
    acc = acc + ACC_W'(c[3*k+1]) * pix_ext(g);
    acc = acc + ACC_W'(c[3*k+2]) * pix_ext(b);
    acc = acc + (ACC_W'(c[NUM_GAIN+k]) <<< COEF_FRAC);
    return clamp_pix(acc);
  endfunction

  // control state
  logic apply_on_r, apply_on_nxt;
  cmt_coef_set_type custom_r, custom_nxt;
  cmt_preset_type preset_r, preset_nxt;
  logic preset_seen_r, preset_seen_nxt;
  cmt_preset_type loaded_r, loaded_nxt;
  logic [COEF_W-1:0] red_ratio_r, red_ratio_nxt;
  logic [COEF_W-1:0] blue_ratio_r, blue_ratio_nxt;
  logic sat_on_r, sat_on_nxt;
  logic [COEF_W-1:0] sat_r, sat_nxt;
  logic [COEF_W-1:0] coef_rd_r, coef_rd_nxt;
  logic apply_rd_r, apply_rd_nxt;
  cmt_coef_set_type active_set;

  // pipeline state: stage 0 capture, 1 correction, 2 saturation, 3 luma/chroma
  logic [PIX_W-1:0] px_r [PIPE_STAGES][3];
  logic [PIX_W-1:0] px_nxt [PIPE_STAGES][3];
  logic [2:0] flag_r [PIPE_STAGES];
  logic [2:0] flag_nxt [PIPE_STAGES];

  // control next state; writes other than white ratio writes are ignored while the pipe is off
  always_comb begin
    apply_on_nxt = apply_on_r;
    custom_nxt = custom_r;
    preset_nxt = preset_r;
    preset_seen_nxt = 1'b1;
    loaded_nxt = loaded_r;
    red_ratio_nxt = red_ratio_r;
    blue_ratio_nxt = blue_ratio_r;
    sat_on_nxt = sat_on_r;
    sat_nxt = sat_r;
    // preset matrix: identity with calibrated red and blue gains
    for (int i = 0; i < NUM_COEF; i++) begin
      active_set[i] = COEF_ZERO;
    end
    active_set[0] = PRESET_RED_GAIN[preset_r];
    active_set[4] = COEF_ONE;
    active_set[8] = PRESET_BLUE_GAIN[preset_r];
    if (preset_r == CMT_CUSTOM) begin
      active_set = custom_r;
    end
    if (i_image_pipe_on) begin
      preset_nxt = cmt_preset_type'(i_illuminant_preset);
      sat_on_nxt = i_chroma_boost_on;
      sat_nxt = i_saturation;
      if (i_transform_apply_wr && i_transform_unit_select == UNIT_CORRECTION) begin
        apply_on_nxt = i_transform_apply_on;
      end
      // luma/chroma coefficients are fixed, so writes to that unit are dropped
      if (i_coefficient_wr && i_transform_unit_select == UNIT_CORRECTION &&
          preset_r == CMT_CUSTOM && i_coefficient_select < SEL_W'(NUM_COEF)) begin
        custom_nxt[i_coefficient_select] = signed'(i_coefficient_value);
      end
    end
    // ratios follow a new preset once, then override writes take over
    if (!preset_seen_r || loaded_r != preset_r) begin
      loaded_nxt = preset_r;
      red_ratio_nxt = PRESET_RED_RATIO[preset_r];
      blue_ratio_nxt = PRESET_BLUE_RATIO[preset_r];
    end
    if (i_ratio_wr) begin
      red_ratio_nxt = i_red_white_ratio;
      blue_ratio_nxt = i_blue_white_ratio;
    end
    // readback of the values actually in use for the selected unit
    coef_rd_nxt = '0;
    apply_rd_nxt = 1'b0;
    if (i_image_pipe_on) begin
      apply_rd_nxt = (i_transform_unit_select == UNIT_LUMA) ? i_yuv_format : apply_on_r;
      if (i_coefficient_select < SEL_W'(NUM_COEF)) begin
        coef_rd_nxt = (i_transform_unit_select == UNIT_LUMA) ?
            LUMA_SET[i_coefficient_select] : active_set[i_coefficient_select];
      end
    end
  end

  // control registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      apply_on_r <= 1'b1;
      for (int i = 0; i < NUM_COEF; i++) begin
        custom_r[i] <= (i == 0 || i == 4 || i == 8) ? COEF_ONE : COEF_ZERO;
      end
      preset_r <= CMT_GENERAL;
      preset_seen_r <= 1'b0;
      loaded_r <= CMT_GENERAL;
      red_ratio_r <= RATIO_RESET;
      blue_ratio_r <= RATIO_RESET;
      sat_on_r <= 1'b0;
      sat_r <= SAT_RESET;
      coef_rd_r <= '0;
      apply_rd_r <= 1'b0;
    end else begin
      apply_on_r <= apply_on_nxt;
      custom_r <= custom_nxt;
      preset_r <= preset_nxt;
      preset_seen_r <= preset_seen_nxt;
      loaded_r <= loaded_nxt;
      red_ratio_r <= red_ratio_nxt;
      blue_ratio_r <= blue_ratio_nxt;
      sat_on_r <= sat_on_nxt;
      sat_r <= sat_nxt;
      coef_rd_r <= coef_rd_nxt;
      apply_rd_r <= apply_rd_nxt;
    end
  end

  // pixel pipeline next state; no stall, every stage advances each clock
  always_comb begin
    logic [PIX_W-1:0] luma;
    logic signed [ACC_W-1:0] acc;
    luma = '0;
    acc = '0;
    px_nxt[0][0] = i_red;
    px_nxt[0][1] = i_green;
    px_nxt[0][2] = i_blue;
    flag_nxt[0] = {i_pix_valid, i_pix_sof, i_pix_eol};
    for (int s = 1; s < PIPE_STAGES; s++) begin
      flag_nxt[s] = flag_r[s-1];
    end
    // correction stage, a plain pass when disabled
    for (int k = 0; k < 3; k++) begin
      px_nxt[1][k] = apply_on_r ?
          row_dot(active_set, k, px_r[0][0], px_r[0][1], px_r[0][2]) : px_r[0][k];
    end
    // saturation pulls each channel away from or toward its luma
    luma = row_dot(LUMA_SET, 0, px_r[1][0], px_r[1][1], px_r[1][2]);
    for (int k = 0; k < 3; k++) begin
      acc = (pix_ext(luma) <<< COEF_FRAC) +
          (pix_ext(px_r[1][k]) - pix_ext(luma)) * ACC_W'($signed({1'b0, sat_r}));
      px_nxt[2][k] = sat_on_r ? clamp_pix(acc) : px_r[1][k];
    end
    // luma/chroma last, driven only by the pixel format
    for (int k = 0; k < 3; k++) begin
      px_nxt[3][k] = i_yuv_format ?
          row_dot(LUMA_SET, k, px_r[2][0], px_r[2][1], px_r[2][2]) : px_r[2][k];
    end
  end

  // pipeline registers; data registers always load so latency never varies
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int s = 0; s < PIPE_STAGES; s++) begin
        flag_r[s] <= 3'h0;
        for (int k = 0; k < 3; k++) begin
          px_r[s][k] <= '0;
        end
      end
    end else begin
      flag_r <= flag_nxt;
      px_r <= px_nxt;
    end
  end

  // outputs, all straight from flip-flops
  assign o_pix_valid = flag_r[PIPE_STAGES-1][2];
  assign o_pix_sof = flag_r[PIPE_STAGES-1][1];
  assign o_pix_eol = flag_r[PIPE_STAGES-1][0];
  assign o_ch0 = px_r[PIPE_STAGES-1][0];
  assign o_ch1 = px_r[PIPE_STAGES-1][1];
  assign o_ch2 = px_r[PIPE_STAGES-1][2];
  assign o_transform_apply_on = apply_rd_r;
  assign o_coefficient_value = coef_rd_r;
  assign o_red_white_ratio = red_ratio_r;
  assign o_blue_white_ratio = blue_ratio_r;

endmodule // cmt_color_matrix_transform

// ### tb/cmt_pix_source.sv
// upstream stage model that hands pixels to the colour matrix transform
`timescale 1ns/1ps
module cmt_pix_source (
  input wire logic i_clock, // clock
  input wire logic i_rst, // reset
  input wire logic i_req, // send a pixel
  input wire logic [1:0] i_mark, // frame, line marks
  input wire logic [29:0] i_rgb, // red, green, blue
  output logic o_valid, // pixel valid
  output logic [1:0] o_mark, // marks out
  output logic [9:0] o_red, // red out
  output logic [9:0] o_green, // green out
  output logic [9:0] o_blue // blue out
);
  // idle cycles carry inverted data so a stale pixel never passes for a live one
  always_ff @(posedge i_clock) begin
    o_valid <= i_req && !i_rst;
    o_mark <= (i_req && !i_rst) ? i_mark : 2'h0;
    {o_red, o_green, o_blue} <= i_req ? i_rgb : ~{o_red, o_green, o_blue};
  end
endmodule // cmt_pix_source

// ### tb/cmt_ctm_monitor.sv
// port-level assertions for the colour matrix transform
`timescale 1ns/1ps
module cmt_ctm_monitor
  import cmt_pkg::*;
(
  input wire logic i_clock, // clock
  input wire logic i_rst, // reset
  input wire logic i_pix_valid, // pixel in
  input wire logic i_pix_sof, // frame mark in
  input wire logic i_pix_eol, // line mark in
  input wire logic o_pix_valid, // pixel out
  input wire logic o_pix_sof, // frame mark out
  input wire logic o_pix_eol, // line mark out
  input wire logic i_image_pipe_on, // pipe enable
  input wire logic i_yuv_format, // yuv format
  input wire logic i_transform_unit_select, // unit
  input wire logic i_transform_apply_wr, // apply strobe
  input wire logic i_transform_apply_on, // apply data
  input wire logic o_transform_apply_on, // apply readback
  input wire logic [SEL_W-1:0] i_coefficient_select, // index
  input wire logic [COEF_W-1:0] o_coefficient_value, // readback
  input wire logic i_ratio_wr, // ratio strobe
  input wire logic [COEF_W-1:0] i_red_white_ratio, // red data
  input wire logic [COEF_W-1:0] i_blue_white_ratio, // blue data
  input wire logic [COEF_W-1:0] o_red_white_ratio, // red out
  input wire logic [COEF_W-1:0] o_blue_white_ratio // blue out
);
  logic [2:0] run_r;
  logic [2:0] run_nxt;
  // cycles since reset; the pipe holds cleared values until it has refilled
  always_comb run_nxt = i_rst ? 3'h0 : ((run_r == 3'h7) ? run_r : run_r + 3'h1);
  always_ff @(posedge i_clock) run_r <= run_nxt;
  default clocking mon_cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_apply_wr;
    i_image_pipe_on && !i_transform_unit_select && i_transform_apply_wr;
  endsequence
  sequence s_luma_q;
    i_image_pipe_on && i_transform_unit_select && i_coefficient_select == SEL_COEFF_ROW0_COL0;
  endsequence
  pix_delay_a: assert property (run_r >= 3'h5 |-> o_pix_valid == $past(i_pix_valid, 4))
    else $error("pixel valid not four cycles late");
  mark_delay_a: assert property (run_r >= 3'h5 |->
    {o_pix_sof, o_pix_eol} == $past({i_pix_sof, i_pix_eol}, 4)) else $error("marks misaligned");
  pipe_off_a: assert property (!i_image_pipe_on |=>
    o_coefficient_value == 16'h0000 && !o_transform_apply_on) else $error("readback while off");
  luma_enable_a: assert property (i_image_pipe_on && i_transform_unit_select |=>
    o_transform_apply_on == $past(i_yuv_format)) else $error("luma enable not format");
  unmapped_sel_a: assert property (i_image_pipe_on && i_coefficient_select >= 4'hc |=>
    o_coefficient_value == 16'h0000) else $error("unmapped index read nonzero");
  ratio_write_a: assert property (i_ratio_wr |=> o_red_white_ratio == $past(i_red_white_ratio)
    && o_blue_white_ratio == $past(i_blue_white_ratio)) else $error("ratio override lost");
  luma_gain_a: assert property (s_luma_q |=> o_coefficient_value == LUMA_SET[0])
    else $error("luma gain readback wrong");
  apply_write_a: assert property (s_apply_wr ##1 (i_image_pipe_on && !i_transform_unit_select)
    |=> o_transform_apply_on == $past(i_transform_apply_on, 2)) else $error("apply write lost");
endmodule // cmt_ctm_monitor
bind cmt_color_matrix_transform cmt_ctm_monitor mon_u (.*);

// ### tb/tb_top.sv
// self-checking bench for the colour matrix transform
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_top
  import cmt_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic src_req = 1'b0;
  logic [1:0] src_mark = 2'h0;
  logic [29:0] src_rgb = 30'h0;
  wire logic i_pix_valid, i_pix_sof, i_pix_eol;
  wire logic [9:0] i_red, i_green, i_blue;
  logic o_pix_valid, o_pix_sof, o_pix_eol, o_transform_apply_on, i_ratio_wr;
  logic [9:0] o_ch0, o_ch1, o_ch2;
  logic i_image_pipe_on, i_yuv_format, i_transform_unit_select, i_transform_apply_wr;
  logic i_transform_apply_on, i_coefficient_wr, i_chroma_boost_on;
  logic [3:0] i_coefficient_select;
  logic [2:0] i_illuminant_preset;
  logic [15:0] i_coefficient_value, o_coefficient_value, i_saturation;
  logic [15:0] i_red_white_ratio, i_blue_white_ratio, o_red_white_ratio, o_blue_white_ratio;
  int n_fail = 0;
  int n_compared = 0;
  always #5 i_clock = ~i_clock;
  cmt_pix_source src_u (.i_clock(i_clock), .i_rst(i_rst), .i_req(src_req), .i_mark(src_mark),
    .i_rgb(src_rgb), .o_valid(i_pix_valid), .o_mark({i_pix_sof, i_pix_eol}), .o_red(i_red),
    .o_green(i_green), .o_blue(i_blue));
  cmt_color_matrix_transform #(.PIX_W(10)) dut_u (.*);
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr_coef(input logic [3:0] sel, input logic [15:0] val);
    @(posedge i_clock);
    i_coefficient_select <= sel;
    i_coefficient_value <= val;
    i_coefficient_wr <= 1'b1;
    @(posedge i_clock);
    i_coefficient_wr <= 1'b0;
  endtask
  // readback is registered, so two edges pass before it is looked at
  task automatic rd_coef(input logic [3:0] sel, input logic [15:0] exp);
    @(posedge i_clock);
    i_coefficient_select <= sel;
    repeat (2) @(posedge i_clock);
    #1 `CHK(o_coefficient_value, exp)
  endtask
  task automatic set_apply(input logic v);
    @(posedge i_clock);
    i_transform_apply_on <= v;
    i_transform_apply_wr <= 1'b1;
    @(posedge i_clock);
    i_transform_apply_wr <= 1'b0;
  endtask
  // one pixel through the source model, then a bounded wait for it at the output
  task automatic pix(input logic [29:0] rgb, input logic [29:0] exp, input logic [1:0] mk);
    int k;
    @(posedge i_clock);
    src_req <= 1'b1;
    src_rgb <= rgb;
    src_mark <= mk;
    @(posedge i_clock);
    src_req <= 1'b0;
    #1;
    for (k = 0; k < 12 && o_pix_valid !== 1'b1; k++) @(posedge i_clock) #1;
    if (k == 12) begin
      n_fail++;
      $display("CHECK FAILED t=%0t pixel never came out", $time);
      print_verdict();
    end else begin
      `CHK({o_ch0, o_ch1, o_ch2}, exp)
      `CHK({o_pix_sof, o_pix_eol}, mk)
      `CHK(k, PIPE_STAGES)
    end
  endtask
  initial begin
    int p;
    {i_transform_unit_select, i_transform_apply_wr, i_transform_apply_on, i_ratio_wr} = 4'h0;
    {i_yuv_format, i_coefficient_wr, i_chroma_boost_on, i_coefficient_select} = 7'h00;
    {i_illuminant_preset, i_coefficient_value, i_saturation} = 35'h0;
    {i_red_white_ratio, i_blue_white_ratio} = 32'h0;
    i_image_pipe_on = 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1 `CHK(o_red_white_ratio, RATIO_RESET)
    `CHK(o_transform_apply_on, 1'b1)
    $display("test reset done");
    for (p = 0; p < 7; p++) begin
      @(posedge i_clock);
      i_illuminant_preset <= p[2:0];
      wr_coef(4'h0, 16'h0123);
      rd_coef(4'h0, PRESET_RED_GAIN[p]);
      rd_coef(4'h8, PRESET_BLUE_GAIN[p]);
      `CHK(o_red_white_ratio, PRESET_RED_RATIO[p])
      `CHK(o_blue_white_ratio, PRESET_BLUE_RATIO[p])
    end
    $display("test presets done");
    @(posedge i_clock);
    i_illuminant_preset <= 3'h7;
    wr_coef(SEL_COEFF_ROW0_COL0, 16'h0800);
    wr_coef(SEL_BIAS_CHANNEL0, 16'h0005);
    wr_coef(4'ha, 16'hffec);
    rd_coef(4'h0, 16'h0800);
    rd_coef(4'h9, 16'h0005);
    rd_coef(4'hc, 16'h0000);
    rd_coef(4'ha, 16'hffec);
    pix({10'h064, 10'h007, 10'h009}, {10'h0cd, 10'h000, 10'h009}, 2'h2);
    pix({10'h258, 10'h01e, 10'h009}, {10'h3ff, 10'h00a, 10'h009}, 2'h1);
    set_apply(1'b0);
    pix({10'h064, 10'h007, 10'h009}, {10'h064, 10'h007, 10'h009}, 2'h0);
    `CHK(o_transform_apply_on, 1'b0)
    $display("test custom done");
    @(posedge i_clock);
    i_image_pipe_on <= 1'b0;
    wr_coef(4'h0, 16'h0c00);
    rd_coef(4'h0, 16'h0000);
    @(posedge i_clock);
    i_image_pipe_on <= 1'b1;
    rd_coef(4'h0, 16'h0800);
    set_apply(1'b1);
    @(posedge i_clock);
    i_chroma_boost_on <= 1'b1;
    pix({10'h064, 10'h007, 10'h009}, {10'h03e, 10'h03e, 10'h03e}, 2'h3);
    @(posedge i_clock);
    i_saturation <= 16'h0800;
    pix({10'h064, 10'h007, 10'h009}, {10'h15c, 10'h000, 10'h000}, 2'h0);
    @(posedge i_clock);
    i_chroma_boost_on <= 1'b0;
    pix({10'h064, 10'h007, 10'h009}, {10'h0cd, 10'h000, 10'h009}, 2'h0);
    $display("test gating done");
    @(posedge i_clock);
    i_transform_unit_select <= 1'b1;
    i_illuminant_preset <= 3'h0;
    set_apply(1'b0);
    for (p = 0; p < 12; p++) rd_coef(p[3:0], LUMA_SET[p]);
    `CHK(o_transform_apply_on, 1'b0)
    @(posedge i_clock);
    i_yuv_format <= 1'b1;
    pix({10'h12c, 10'h12c, 10'h12c}, {10'h12c, 10'h200, 10'h200}, 2'h1);
    `CHK(o_transform_apply_on, 1'b1)
    @(posedge i_clock);
    i_transform_unit_select <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1 `CHK(o_transform_apply_on, 1'b1)
    rd_coef(4'h0, PRESET_RED_GAIN[0]);
    $display("test luma done");
    @(posedge i_clock);
    i_ratio_wr <= 1'b1;
    i_red_white_ratio <= 16'h0511;
    i_blue_white_ratio <= 16'h0322;
    @(posedge i_clock);
    i_ratio_wr <= 1'b0;
    #1 `CHK({o_red_white_ratio, o_blue_white_ratio}, 32'h0511_0322)
    $display("test ratios done");
    print_verdict();
  end
endmodule // tb_top
